// ### include/prox_filter_pkg.sv
// Overview of operation
// - averaging bit set reports mean of newest and previous sample, else newest
// - averaging works on offset-cancelled values only, after the cancellation stage
// - nonzero hysteresis field starts in peak mode, reporting highest count so far
// - in peak mode, sample below peak minus amount switches to baseline tracking
// - in baseline mode, sample above baseline plus amount switches to peak tracking
// - subtract the sixteen-bit host cancellation level from every raw measurement first
package prox_filter_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CANCEL_LO  = 8'h1b;
  localparam logic [7:0] ADDR_CANCEL_HI  = 8'h1c;
  localparam logic [7:0] ADDR_FILTER_CFG = 8'h1d;

  localparam logic [7:0]  RST_FILTER_CFG = 8'h00;
  localparam logic [15:0] RST_CANCEL     = 16'h0000;
  localparam logic [15:0] RST_RESULT     = 16'h0000;

  // ----------------------------------------
  // field layout of prox_filter_config
  // ----------------------------------------
  localparam int AVG_ON_BIT    = 7;
  localparam int HYST_BAND_MSB = 6;

  // ----------------------------------------
  // hysteresis tracker states
  // ----------------------------------------
  typedef enum logic [1:0] {
    HY_BYPASS = 2'b00,
    HY_PEAK   = 2'b01,
    HY_BASE   = 2'b11
  } hyst_state_t;

endpackage

// ### logic/prox_avg_hysteresis_filter.sv
`timescale 1ns/1ns
`default_nettype none
module prox_avg_hysteresis_filter
  import prox_filter_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // register port
  input  wire logic        REG_WR_EN,
  input  wire logic        REG_RD_EN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output var  logic [7:0]  REG_RDATA,
  // measurement front end
  input  wire logic        MEAS_VALID,
  input  wire logic [15:0] MEAS_RAW,
  // result
  output var  logic [15:0] PROX_RESULT_VALUE,
  output var  logic        RESULT_VALID,
  output var  logic        HYST_PEAK_MODE
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction

  function automatic logic [16:0] wide_add(input logic [15:0] a, input logic [15:0] b);
    wide_add = {1'b0, a} + {1'b0, b};
  endfunction

  // peak side: a peak below the band cannot drop out, so the subtraction never wraps
  function automatic logic fell_out(input logic [15:0] sample, input logic [15:0] hold, input logic [15:0] amt);
    fell_out = (hold >= amt) && (sample < hold - amt);
  endfunction

  // baseline side: the sum is one bit wider so a high baseline never wraps past the band
  function automatic logic rose_out(input logic [15:0] sample, input logic [15:0] hold, input logic [15:0] amt);
    rose_out = {1'b0, sample} > wide_add(hold, amt);
  endfunction

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic [15:0] cancel_ff;
  logic [15:0] nxt_cancel;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        cfg_wr;

  // the cancel bytes are written one at a time; between the two writes a mixed level applies
  assign cfg_wr = REG_WR_EN && (REG_ADDR == ADDR_FILTER_CFG);

  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_cancel = cancel_ff;
    nxt_rdata  = rdata_ff;
    if (REG_WR_EN) begin
      case (REG_ADDR)
        ADDR_CANCEL_LO:  nxt_cancel[7:0]  = REG_WDATA;
        ADDR_CANCEL_HI:  nxt_cancel[15:8] = REG_WDATA;
        ADDR_FILTER_CFG: nxt_cfg          = REG_WDATA;
        default:         nxt_cfg          = cfg_ff;
      endcase
    end
    // read data is registered: it answers one cycle after the strobe and stands until the next read
    if (REG_RD_EN) begin
      case (REG_ADDR)
        ADDR_CANCEL_LO:  nxt_rdata = cancel_ff[7:0];
        ADDR_CANCEL_HI:  nxt_rdata = cancel_ff[15:8];
        ADDR_FILTER_CFG: nxt_rdata = cfg_ff;
        // unmapped addresses read as zero
        default:         nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      cfg_ff    <= RST_FILTER_CFG;
      cancel_ff <= RST_CANCEL;
      rdata_ff  <= 8'h00;
    end else begin
      cfg_ff    <= nxt_cfg;
      cancel_ff <= nxt_cancel;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // offset cancellation and averaging
  // ----------------------------------------
  logic        avg_on;
  logic [6:0]  hyst_band;
  logic [15:0] hyst_amount;
  logic [15:0] cancelled;
  logic [15:0] prev_sample;
  logic        prev_valid;
  logic [16:0] pair_sum;
  logic [15:0] smoothed;

  // fields are decoded straight from the stored byte, so a write takes effect on the next sample
  assign avg_on      = cfg_ff[AVG_ON_BIT];
  assign hyst_band   = cfg_ff[HYST_BAND_MSB:0];
  assign hyst_amount = {8'h00, hyst_band, 1'b0};

  // clamp at zero: a cancellation level above the raw count must not wrap
  assign cancelled = sat_sub(MEAS_RAW, cancel_ff);

  // history holds cancelled values, so averaging sits after cancellation
  prox_prev_store u_prev (
    .CLK_SYS    (CLK_SYS),
    .RSTN       (RSTN),
    .STORE_EN   (MEAS_VALID),
    .STORE_DATA (cancelled),
    .CLEAR      (cfg_wr),
    .PREV_DATA  (prev_sample),
    .PREV_VALID (prev_valid)
  );

  // the mean is floored: a pair one count apart reports the lower count
  assign pair_sum = wide_add(cancelled, prev_sample);
  // with no earlier sample yet, the newest one is reported alone
  assign smoothed = (avg_on && prev_valid) ? pair_sum[16:1] : cancelled;

  // ----------------------------------------
  // hysteresis tracker
  // ----------------------------------------
  hyst_state_t state_ff;
  hyst_state_t nxt_state;
  logic [15:0] hold_ff;
  logic [15:0] nxt_hold;
  logic        started_ff;
  logic        nxt_started;
  logic        valid_ff;
  logic        nxt_valid;
  logic        peak_ff;
  logic        nxt_peak;

  // started_ff marks that the tracker holds a real sample since the last restart
  always_comb begin
    nxt_state   = state_ff;
    nxt_hold    = hold_ff;
    nxt_started = started_ff;
    nxt_valid   = 1'b0;
    if (cfg_wr) begin
      // a new configuration restarts tracking in bypass; the next sample with a nonzero band enters peak mode
      // a sample on the same cycle is dropped; the restart takes its place
      nxt_state   = HY_BYPASS;
      nxt_started = 1'b0;
    end else if (MEAS_VALID) begin
      nxt_valid = 1'b1;
      if (hyst_band == 7'h00) begin
        nxt_state   = HY_BYPASS;
        nxt_hold    = smoothed;
        nxt_started = 1'b0;
      end else if (!started_ff) begin
        nxt_state   = HY_PEAK;
        nxt_hold    = smoothed;
        nxt_started = 1'b1;
      end else begin
        // strict compares: a sample right on the band edge keeps the current mode
        case (state_ff)
          HY_PEAK: begin
            if (fell_out(smoothed, hold_ff, hyst_amount)) begin
              nxt_state = HY_BASE;
              nxt_hold  = smoothed;
            end else if (smoothed > hold_ff) begin
              nxt_hold = smoothed;
            end
          end
          HY_BASE: begin
            if (rose_out(smoothed, hold_ff, hyst_amount)) begin
              nxt_state = HY_PEAK;
              nxt_hold  = smoothed;
            end else if (smoothed < hold_ff) begin
              nxt_hold = smoothed;
            end
          end
          // not reached along the usual path; recover as a fresh peak
          default: begin
            nxt_state = HY_PEAK;
            nxt_hold  = smoothed;
          end
        endcase
      end
    end
    // the mode flag comes from the next state so it changes together with the held value
    nxt_peak = (nxt_state == HY_PEAK);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state_ff   <= HY_BYPASS;
      hold_ff    <= RST_RESULT;
      started_ff <= 1'b0;
      valid_ff   <= 1'b0;
      peak_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      hold_ff    <= nxt_hold;
      started_ff <= nxt_started;
      valid_ff   <= nxt_valid;
      peak_ff    <= nxt_peak;
    end
  end

  // ----------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------
  assign REG_RDATA         = rdata_ff;
  assign PROX_RESULT_VALUE = hold_ff;
  assign RESULT_VALID      = valid_ff;
  assign HYST_PEAK_MODE    = peak_ff;

endmodule // prox_avg_hysteresis_filter
`default_nettype wire

// ### logic/prox_prev_store.sv
`timescale 1ns/1ns
`default_nettype none
module prox_prev_store
  import prox_filter_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // store
  input  wire logic        STORE_EN,
  input  wire logic [15:0] STORE_DATA,
  input  wire logic        CLEAR,
  // read
  output var  logic [15:0] PREV_DATA,
  output var  logic        PREV_VALID
);

  logic [15:0] data_ff;
  logic [15:0] nxt_data;
  logic        valid_ff;
  logic        nxt_valid;

  always_comb begin
    nxt_data  = data_ff;
    nxt_valid = valid_ff;
    if (CLEAR) begin
      nxt_valid = 1'b0;
    end else if (STORE_EN) begin
      nxt_data  = STORE_DATA;
      nxt_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      data_ff  <= RST_RESULT;
      valid_ff <= 1'b0;
    end else begin
      data_ff  <= nxt_data;
      valid_ff <= nxt_valid;
    end
  end

  assign PREV_DATA  = data_ff;
  assign PREV_VALID = valid_ff;

endmodule // prox_prev_store
`default_nettype wire

// ### testbench/prox_avg_hysteresis_filter_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module prox_avg_hysteresis_filter_assertions
  import prox_filter_pkg::*;
(
  // clock, register port
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        REG_WR_EN,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  // samples and result
  input wire logic        MEAS_VALID,
  input wire logic [15:0] PROX_RESULT_VALUE,
  input wire logic        RESULT_VALID,
  input wire logic        HYST_PEAK_MODE
);
  // --------------------------------
  // shadow of band and last result
  // --------------------------------
  wire         wr_cfg = REG_WR_EN && REG_ADDR == ADDR_FILTER_CFG;
  logic [6:0]  bd_ff;
  logic [15:0] lv_ff;
  logic        md_ff;
  logic        rs_ff;
  wire  [15:0] amt = {8'h00, bd_ff, 1'b0};
  wire  [16:0] lv_top = {1'b0, lv_ff} + {1'b0, amt};
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      bd_ff <= 7'h00;
      rs_ff <= 1'b1;
    end else begin
      if (wr_cfg) bd_ff <= REG_WDATA[6:0];
      if (RESULT_VALID) lv_ff <= PROX_RESULT_VALUE;
      if (RESULT_VALID) md_ff <= HYST_PEAK_MODE;
      rs_ff <= wr_cfg || (rs_ff && !RESULT_VALID);
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence s_sample; MEAS_VALID && !wr_cfg; endsequence
  sequence s_hold; RESULT_VALID && !rs_ff; endsequence
  chk_result_follows: assert property (s_sample |=> RESULT_VALID)
    else $error("no result after sample");
  chk_no_spurious: assert property (RESULT_VALID |-> $past(MEAS_VALID))
    else $error("result without sample");
  chk_band_zero: assert property (bd_ff == 7'h00 |=> !HYST_PEAK_MODE)
    else $error("peak mode with zero band");
  chk_peak_hold: assert property (s_hold ##0 (HYST_PEAK_MODE && md_ff) |-> PROX_RESULT_VALUE >= lv_ff)
    else $error("peak fell");
  chk_base_hold: assert property (s_hold ##0 (!HYST_PEAK_MODE && !md_ff && bd_ff != 7'h00) |-> PROX_RESULT_VALUE <= lv_ff)
    else $error("baseline rose");
  chk_to_base: assert property (s_hold ##0 (!HYST_PEAK_MODE && md_ff) |-> PROX_RESULT_VALUE < lv_ff - amt)
    else $error("early switch to baseline");
  chk_to_peak: assert property (s_hold ##0 (HYST_PEAK_MODE && !md_ff) |-> PROX_RESULT_VALUE > lv_top)
    else $error("early switch to peak");
  chk_mode_cause: assert property ($changed(HYST_PEAK_MODE) |-> RESULT_VALID || $past(wr_cfg))
    else $error("mode changed without cause");
endmodule // prox_avg_hysteresis_filter_assertions
bind prox_avg_hysteresis_filter prox_avg_hysteresis_filter_assertions u_chk (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_WR_EN(REG_WR_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .MEAS_VALID(MEAS_VALID), .PROX_RESULT_VALUE(PROX_RESULT_VALUE), .RESULT_VALID(RESULT_VALID),
  .HYST_PEAK_MODE(HYST_PEAK_MODE));
`default_nettype wire

// ### testbench/prox_avg_hysteresis_filter_test.sv
`timescale 1ns/1ns
`default_nettype none
module prox_avg_hysteresis_filter_test;
  import prox_filter_pkg::*;
  // --------------------------------
  // stimulus and reference state
  // --------------------------------
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [15:0] raw = 16'h0000, lf = 16'hfaa8;
  wire [7:0] rdata;
  wire [15:0] mraw, res;
  wire mv, rv, pk;
  int n_mismatch = 0, tests_run = 0, cfg = 0, can = 0, prev = 0, pv = 0, md = 0, held = 0, st = 0;
  int exp_q[$];
  logic [7:0] cf[5] = '{8'h00, 8'h80, 8'h05, 8'h85, 8'h7f};
  logic [7:0] cl[5] = '{8'h00, 8'h40, 8'h10, 8'h20, 8'h00};
  logic [7:0] ch[5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  always #10 clk = ~clk;
  prox_front_model u_prox_front_model (.clk(clk), .req(req), .raw_in(raw), .meas_valid(mv), .meas_raw(mraw));
  prox_avg_hysteresis_filter u_prox_avg_hysteresis_filter (.CLK_SYS(clk), .RSTN(rstn), .REG_WR_EN(wr),
    .REG_RD_EN(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .MEAS_VALID(mv),
    .MEAS_RAW(mraw), .PROX_RESULT_VALUE(res), .RESULT_VALID(rv), .HYST_PEAK_MODE(pk));
  function automatic logic [15:0] nxt_rand(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_res(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 {wr, addr, wdata} = {1'b1, a, d};
    @(posedge clk);
    #2 wr = 1'b0;
    if (a == ADDR_CANCEL_LO) can = (can & 32'hff00) | d;
    if (a == ADDR_CANCEL_HI) can = (can & 32'h00ff) | (d << 8);
    if (a == ADDR_FILTER_CFG) {cfg, pv, st} = {24'h0, d, 64'h0};
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #2 {rd, addr} = {1'b1, a};
    @(posedge clk);
    #2 rd = 1'b0;
    cmp_reg(rdata, e);
  endtask
  task automatic burst(input int n);
    int c, p, amt;
    amt = 2 * (cfg % 128);
    repeat (n) begin
      @(posedge clk);
      #2 lf = nxt_rand(lf);
      {req, raw} = {1'b1, 6'h00, lf[9:0]};
      c = raw > can ? raw - can : 0;
      p = (cfg[7] && pv) ? (c + prev) >> 1 : c;
      {prev, pv} = {c, 32'h1};
      if (amt == 0) {md, held} = {32'h0, p};
      else if (!st) {st, md, held} = {64'h1_0000_0001, p};
      else if (md) begin
        if (p < held - amt) {md, held} = {32'h0, p};
        else if (p > held) held = p;
      end else if (p > held + amt) {md, held} = {32'h1, p};
      else if (p < held) held = p;
      exp_q.push_back(md * 65536 + held);
    end
    @(posedge clk);
    #2 req = 1'b0;
  endtask
  task automatic wr_on_sample(input logic [7:0] d);
    @(posedge clk);
    #2 {wr, addr, wdata, req, raw} = {1'b1, ADDR_FILTER_CFG, d, 1'b1, 16'h0155};
    @(posedge clk);
    #2 {wr, req} = 2'b00;
    {cfg, pv, st} = {24'h0, d, 64'h0};
  endtask
  always @(negedge clk) if (rv === 1'b1) begin
    if (exp_q.size() == 0) cmp_res({pk, res}, 17'h1ffff);
    else cmp_res({pk, res}, 17'(exp_q.pop_front()));
  end
  initial begin
    #400000 n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    #2 rstn = 1'b1;
    rd_reg(ADDR_FILTER_CFG, RST_FILTER_CFG);
    rd_reg(ADDR_CANCEL_LO, RST_CANCEL[7:0]);
    wr_reg(8'h1e, 8'hff);
    rd_reg(8'h1e, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr_reg(ADDR_CANCEL_LO, cl[i]);
      wr_reg(ADDR_CANCEL_HI, ch[i]);
      wr_reg(ADDR_FILTER_CFG, cf[i]);
      rd_reg(ADDR_FILTER_CFG, cf[i]);
      rd_reg(ADDR_CANCEL_HI, ch[i]);
      burst(40);
    end
    wr_on_sample(8'h83);
    burst(12);
    repeat (4) @(posedge clk);
    cmp_res(17'(exp_q.size()), 17'h00000);
    report_and_stop();
  end
endmodule // prox_avg_hysteresis_filter_test
`default_nettype wire

// ### testbench/prox_front_model.sv
`timescale 1ns/1ns
`default_nettype none
module prox_front_model (
  // bench side
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [15:0] raw_in,
  // design side
  output var  logic        meas_valid,
  output var  logic [15:0] meas_raw
);
  // idle count is the inverse of the last one, so a stale sample never looks valid
  logic [15:0] last_ff = 16'h0000;
  assign meas_valid = req;
  assign meas_raw   = req ? raw_in : ~last_ff;
  always_ff @(posedge clk) if (req) last_ff <= raw_in;
endmodule // prox_front_model
`default_nettype wire
